// ---- hdl/gate_cfg.svh ----
// timing and mode constants for the gate driver fault feedback block
`ifndef GATE_CFG_SVH
`define GATE_CFG_SVH
`define CLK_MHZ          125
`define ACK_NS           900
`define ACK_CYC          ((`ACK_NS * `CLK_MHZ + 999) / 1000)
`define SC_CHECK_NS      8500
`define SC_CHECK_CYC     ((`SC_CHECK_NS * `CLK_MHZ + 999) / 1000)
`define SC_MAX_NS        10000
`define SC_MAX_CYC       ((`SC_MAX_NS * `CLK_MHZ) / 1000)
`define FAULT_HOLD_MS    1000
`define FAULT_HOLD_CYC   (`FAULT_HOLD_MS * `CLK_MHZ * 1000)
`define MODE_2LEVEL      1'h0
`define MODE_3LEVEL      1'h1
`endif

// ---- hdl/gate_pkg.sv ----
// types shared by the gate driver fault feedback block
`default_nettype none
package gate_pkg;
  typedef enum logic [1:0] {st_off, st_wait, st_on, st_trip} gate_st_t;
  typedef struct packed {
    logic cmd;
    logic sc_sense;
    logic supply_ok;
  } drv_in_t;
endpackage
`default_nettype wire

// ---- hdl/pulse_timer.sv ----
// loadable down counter used for ack, check and hold delays
`default_nettype none
module pulse_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt;
  wire  logic   at_one = (cnt == W'(1));
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load) begin
        cnt <= count;
      end else if (cnt != '0) begin
        cnt  <= cnt - W'(1);
        done <= at_one;
      end
    end
  end
  assign busy = (cnt != '0);
endmodule
`default_nettype wire

// ---- hdl/gate_fault_feedback.sv ----
// command, short-circuit protection (gate trip in 2-level mode only, fault flag in both modes) and status feedback of the gate driver
`include "gate_cfg.svh"
`default_nettype none
module gate_fault_feedback #(
  parameter int HOLD_CYC = `FAULT_HOLD_CYC,
  parameter int HW       = 28
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire gate_pkg::drv_in_t pins,
  input  wire logic             topology_mode_select,
  output logic                  gate_on,
  output logic                  status_light,
  output logic                  fault
);
  localparam int AW = 8;
  localparam int CW = 11;

  // three-stage synchronisers for the pin inputs
  logic [2:0] cmd_s, sc_s, sup_s;
  logic       cmd_q, sc_q, sup_q, mode;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_s <= 3'h0;
      sc_s  <= 3'h0;
      sup_s <= 3'h0;
      cmd_q <= 1'b0;
      sc_q  <= 1'b0;
      sup_q <= 1'b0;
      mode  <= `MODE_2LEVEL;
    end else if (ce) begin
      cmd_s <= {cmd_s[1:0], pins.cmd};
      sc_s  <= {sc_s[1:0], pins.sc_sense};
      sup_s <= {sup_s[1:0], pins.supply_ok};
      if (cmd_s[2] == cmd_s[1]) cmd_q <= cmd_s[2];
      if (sc_s[2] == sc_s[1]) sc_q <= sc_s[2];
      if (sup_s[2] == sup_s[1]) sup_q <= sup_s[2];
      mode <= topology_mode_select;
    end
  end

  wire logic cmd_edge = (cmd_s[2] == cmd_s[1]) && (cmd_s[2] != cmd_q);
  wire logic cmd_rise = cmd_edge && cmd_s[2];

  // acknowledge pulse timer
  logic ack_busy;
  pulse_timer #(.W(AW)) u_ack (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .load  (cmd_edge),
    .count (AW'(`ACK_CYC)),
    .busy  (ack_busy),
    .done  ()
  );

  // short-circuit check timer started by turn-on
  logic chk_done;
  pulse_timer #(.W(CW)) u_chk (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .load  (cmd_rise),
    .count (CW'(`SC_CHECK_CYC)),
    .busy  (),
    .done  (chk_done)
  );

  wire logic sc_hit = chk_done && cmd_q && sc_q;

  // one-second fault hold
  logic hold_busy;
  pulse_timer #(.W(HW)) u_hold (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .load  (sc_hit),
    .count (HW'(HOLD_CYC)),
    .busy  (hold_busy),
    .done  ()
  );

  gate_pkg::gate_st_t st, next_st;
  always_comb begin
    next_st = st;
    case (st)
      gate_pkg::st_off:  if (cmd_rise) next_st = gate_pkg::st_wait;
      gate_pkg::st_wait: begin
        if (!cmd_q) next_st = gate_pkg::st_off;
        else if (sc_hit && mode == `MODE_2LEVEL)
          next_st = gate_pkg::st_trip;
        else if (chk_done) next_st = gate_pkg::st_on;
      end
      gate_pkg::st_on:   if (!cmd_q) next_st = gate_pkg::st_off;
      gate_pkg::st_trip: if (!cmd_q) next_st = gate_pkg::st_off;
      default:           next_st = gate_pkg::st_off;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st           <= gate_pkg::st_off;
      gate_on      <= 1'b0;
      status_light <= 1'b0;
      fault        <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      gate_on <= (next_st == gate_pkg::st_wait) ||
                 (next_st == gate_pkg::st_on);
      fault <= hold_busy || sc_hit;
      status_light <= sup_q && !hold_busy && !sc_hit && !ack_busy &&
                      !cmd_edge;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_light_fault: assert property (
    fault |-> !status_light)
    else $error("status lit during fault");
  chk_ack_pulse: assert property (
    ce && cmd_edge && sup_q && !hold_busy |=> !status_light)
    else $error("no ack pulse after edge");
  chk_trip_off: assert property (
    st == gate_pkg::st_trip |-> !gate_on || $past(st) != gate_pkg::st_trip)
    else $error("gate on after trip");
  chk_hold_dark: assert property (
    ce && sc_hit |=> fault && !status_light)
    else $error("fault not held");
  chk_three_on: assert property (
    ce && sc_hit && mode == `MODE_3LEVEL && cmd_q |=> gate_on)
    else $error("3-level switched off on fault");
  chk_gate_cmd: assert property (
    ce && !cmd_q && !cmd_edge |=> !gate_on)
    else $error("gate on without command");
  chk_no_early: assert property (
    ce && cmd_rise |=> !sc_hit [*8])
    else $error("early short check");
  chk_light_back: assert property (
    ce && sup_q && !hold_busy && !ack_busy && !cmd_edge && !sc_hit
      |=> status_light)
    else $error("status not restored");
  cov_ack: cover property (cmd_edge ##1 !status_light);
  cov_trip: cover property (st == gate_pkg::st_trip);
  cov_three: cover property (sc_hit && mode == `MODE_3LEVEL);
endmodule
`default_nettype wire

// ---- verification/host_model.sv ----
// host controller model on the command and status links
`default_nettype none
module host_model (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic status_light,
  output logic      cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  int dark = 0;
  // watch status; dark longer than an ack reads as fault or link loss
  always_ff @(posedge clk) begin
    dark <= status_light ? 0 : dark + 1;
  end
  // long dark: host commands the switch off itself
  assign cmd = want && (dark < 150);
endmodule
`default_nettype wire

// ---- verification/gate_fault_feedback_tb.sv ----
// self-checking bench of the gate driver fault feedback block
`default_nettype none
module gate_fault_feedback_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, ce = 1, want = 0, sc = 0, sup = 1, mode = 0;
  logic cmd, gate_on, status_light, fault;
  int   n_mismatch = 0, checked = 0, n;
  gate_pkg::drv_in_t pins;
  assign pins = {cmd, sc, sup};
  gate_fault_feedback #(.HOLD_CYC(200)) u_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .pins(pins),
    .topology_mode_select(mode), .gate_on(gate_on),
    .status_light(status_light), .fault(fault));
  host_model u_host (.clk(clk), .want(want),
    .status_light(status_light), .cmd(cmd));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_edge(input logic v);
    want = v;
    cyc(8);
    chk(gate_on, v);
    chk(status_light, 1'h0);
    n = 0;
    while (!status_light && n < 200) begin
      cyc(1);
      n++;
    end
    chk(n >= 108 && n <= 118, 1'h1);
  endtask
  task automatic t_short(input logic m);
    mode = m;
    sc = 1;
    want = 1;
    cyc(1060);
    chk(gate_on, 1'h1);
    chk(fault, 1'h0);
    cyc(12);
    chk(fault, 1'h1);
    chk(status_light, 1'h0);
    chk(gate_on, m);
    cyc(100);
    chk(fault, 1'h1);
    chk(gate_on, m);
    cyc(100);
    chk(gate_on, 1'h0);
    sc = 0;
    want = 0;
    cyc(300);
    chk(fault, 1'h0);
    chk(status_light, 1'h1);
  endtask
  task automatic t_supply();
    ce = 0;
    sup = 0;
    cyc(8);
    chk(status_light, 1'h1);
    ce = 1;
    cyc(8);
    chk(status_light, 1'h0);
    sup = 1;
    cyc(8);
    chk(status_light, 1'h1);
  endtask
  initial begin
    cyc(4);
    nrst = 1;
    cyc(8);
    chk(status_light, 1'h1);
    t_edge(1'h1);
    t_edge(1'h0);
    t_supply();
    t_short(1'h0);
    t_short(1'h1);
    t_edge(1'h1);
    tally_and_finish();
  end
  initial begin
    cyc(10000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
